/* rtl/pss_pkg.sv */
// Package with types and constants for the power state sequencer.
package pss_pkg;

	// Operating states of the sequencer, one-hot.
	typedef enum logic [8:0] {
		PSS_POR = 9'h001,
		PSS_FUSE = 9'h002,
		PSS_SAMPLE = 9'h004,
		PSS_FLASH_EMU = 9'h008,
		PSS_MIN_ENERGY = 9'h010,
		PSS_BOOT = 9'h020,
		PSS_RUN = 9'h040,
		PSS_SLEEP = 9'h080,
		PSS_DOZE = 9'h100
	} pss_state_type;

	// Demand and wake inputs from the rest of the chip.
	typedef struct packed {
		logic cpu_busy;
		logic cpu_wfi;
		logic periph_busy;
		logic dma_busy;
		logic irq_pending;
	} pss_demand_type;

	// Clock and power controls driven by the sequencer.
	typedef struct packed {
		logic relax_osc_en;
		logic cpu_clk_en;
		logic periph_clk_en;
		logic lf_osc_en;
		logic timers_en;
		logic retain_en;
		logic io_wake_en;
		logic core_pwr_en;
		logic flash_emu_en;
		logic normal_op_en;
	} pss_power_type;

	// Relaxation oscillator settle time and the rate of this clock.
	localparam int PSS_CLK_HZ = 20_000_000;
	localparam int PSS_OSC_START_NS = 2_000;
	localparam int PSS_OSC_START_CYC = (PSS_OSC_START_NS * (PSS_CLK_HZ / 1_000_000)
		+ 999) / 1_000;
	localparam int PSS_POR_CYC = 16;
	localparam int PSS_FUSE_CYC = 32;
	localparam int PSS_BOOT_CYC = 64;
	localparam int PSS_CNT_W = 12;
	localparam logic [PSS_CNT_W-1:0] PSS_CNT_RST = 12'h000;

endpackage

/* rtl/pss_sequencer.sv */
// Power state sequencer: start-up, flash emulation select and operating states.
//
// Function
// - Power-on or hard reset input restarts the start-up sequence.
// - After power-on or synchronized hard reset falls, load the fuse table.
// - Sample both inputs in start-up; both asserted selects flash emulation.
// - Hard reset without program request holds minimum energy until release.
// - Hard reset release runs boot then enters active.
// - Flash emulation suspends normal operation and acts as serial flash.
// - Operating states pick lowest power meeting demand.
// - Active keeps relaxation oscillator running, peripherals enabled when needed.
// - Active alternates CPU running and CPU sleeping substates.
// - Peripherals and DMA move between active and doze without CPU.
// - Doze only when CPU and all peripherals are idle.
// - Doze retains state and keeps timekeeping running.
// - Doze watches I/O pins and wakes quickly on activity.
// - Doze keeps low-frequency oscillator and its timers running.
// - Relaxation oscillator clocks CPU and peripherals, starts quickly leaving doze.
`timescale 1ns/10ps

module pss_sequencer #(
	parameter int POR_CYC = pss_pkg::PSS_POR_CYC,
	parameter int FUSE_CYC = pss_pkg::PSS_FUSE_CYC,
	parameter int BOOT_CYC = pss_pkg::PSS_BOOT_CYC,
	parameter int OSC_CYC = pss_pkg::PSS_OSC_START_CYC,
	parameter int FUSE_W = 16
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic hard_rst_l,
	input wire logic prog_mode_req_l,
	input wire logic time_capture_req_l,
	input wire logic uart_rx_l,
	input wire logic uart_rts_l,
	input wire pss_pkg::pss_demand_type demand,
	input wire logic [FUSE_W-1:0] fuse_data,
	output pss_pkg::pss_power_type power,
	output pss_pkg::pss_state_type state,
	output logic [FUSE_W-1:0] io_dir,
	output logic fuse_loaded,
	output logic wake_event
);
	import pss_pkg::*;

	// Counts below one or the fuse word of no width cannot be served.
	if (POR_CYC < 1 || FUSE_CYC < 1 || BOOT_CYC < 1 || OSC_CYC < 1 ||
		FUSE_W < 1) begin : g_bad_low
		$error("pss_sequencer: counts and fuse width must be at least 1");
	end
	// Each count is loaded minus one into the down-counter and must fit it.
	if (POR_CYC > (1 << PSS_CNT_W) || FUSE_CYC > (1 << PSS_CNT_W) ||
		BOOT_CYC > (1 << PSS_CNT_W) || OSC_CYC > (1 << PSS_CNT_W)) begin : g_bad_high
		$error("pss_sequencer: counts must fit the down-counter");
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset release and input synchronizers.

	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [1:0] hrst_meta_q, prog_meta_q, time_meta_q, rx_meta_q, rts_meta_q;
	logic hrst_l_q, prog_l_q, time_l_q, rx_l_q, rts_l_q;
	logic hrst_prev_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hrst_meta_q <= 2'h3;
			prog_meta_q <= 2'h3;
			time_meta_q <= 2'h3;
			rx_meta_q <= 2'h3;
			rts_meta_q <= 2'h3;
			hrst_prev_q <= 1'b1;
		end else begin
			hrst_meta_q <= {hrst_meta_q[0], hard_rst_l};
			prog_meta_q <= {prog_meta_q[0], prog_mode_req_l};
			time_meta_q <= {time_meta_q[0], time_capture_req_l};
			rx_meta_q <= {rx_meta_q[0], uart_rx_l};
			rts_meta_q <= {rts_meta_q[0], uart_rts_l};
			hrst_prev_q <= hrst_meta_q[1];
		end
	end
	assign hrst_l_q = hrst_meta_q[1];
	assign prog_l_q = prog_meta_q[1];
	assign time_l_q = time_meta_q[1];
	assign rx_l_q = rx_meta_q[1];
	assign rts_l_q = rts_meta_q[1];

	logic hrst_fall;
	logic hrst_on, prog_on;
	assign hrst_on = !hrst_l_q;
	assign prog_on = !prog_l_q;
	assign hrst_fall = hrst_prev_q && !hrst_l_q;

	////////////////////////////////////////////////////////////////////////////
	// State machine.

	pss_state_type state_q, state_d;
	logic [PSS_CNT_W-1:0] cnt_q, cnt_d;
	logic [FUSE_W-1:0] io_dir_q, io_dir_d;
	logic fuse_q, fuse_d;
	logic osc_ok_q, osc_ok_d;
	logic io_act;
	logic demand_any;
	logic cnt_done;

	// activity on UART lines or time capture request.
	assign io_act = !time_l_q || !rx_l_q || !rts_l_q;
	assign demand_any = demand.cpu_busy || demand.periph_busy || demand.dma_busy ||
		demand.irq_pending;
	assign cnt_done = (cnt_q == PSS_CNT_RST);

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		io_dir_d = io_dir_q;
		fuse_d = fuse_q;
		osc_ok_d = osc_ok_q;
		if (!cnt_done) begin
			cnt_d = cnt_q - 12'h001;
		end
		case (state_q)
			PSS_POR: begin
				if (cnt_done) begin
					state_d = PSS_FUSE;
					cnt_d = PSS_CNT_W'(FUSE_CYC - 1);
				end
			end
			PSS_FUSE: begin
				if (cnt_done) begin
					io_dir_d = fuse_data;
					fuse_d = 1'b1;
					state_d = PSS_SAMPLE;
				end
			end
			PSS_SAMPLE: begin
				if (hrst_on && prog_on) begin
					state_d = PSS_FLASH_EMU;
				end else if (hrst_on) begin
					state_d = PSS_MIN_ENERGY;
				end else begin
					state_d = PSS_BOOT;
					cnt_d = PSS_CNT_W'(BOOT_CYC - 1);
				end
			end
			PSS_FLASH_EMU: begin
				// stay emulating until hard reset release.
				if (!hrst_on) begin
					state_d = PSS_BOOT;
					cnt_d = PSS_CNT_W'(BOOT_CYC - 1);
				end
			end
			PSS_MIN_ENERGY: begin
				if (!hrst_on) begin
					state_d = PSS_BOOT;
					cnt_d = PSS_CNT_W'(BOOT_CYC - 1);
				end
			end
			PSS_BOOT: begin
				if (cnt_done) begin
					state_d = PSS_RUN;
					osc_ok_d = 1'b1;
				end
			end
			PSS_RUN: begin
				if (demand.cpu_wfi && !demand.cpu_busy) begin
					state_d = PSS_SLEEP;
				end
			end
			PSS_SLEEP: begin
				if (demand.cpu_busy || demand.irq_pending) begin
					state_d = PSS_RUN;
				end else if (!demand_any && !io_act) begin
					state_d = PSS_DOZE;
					osc_ok_d = 1'b0;
				end
			end
			PSS_DOZE: begin
				// peripherals, DMA or I/O wake without the CPU.
				if (demand_any || io_act) begin
					state_d = PSS_SLEEP;
					cnt_d = PSS_CNT_W'(OSC_CYC - 1);
				end
			end
			default: begin
				state_d = PSS_POR;
				cnt_d = PSS_CNT_W'(POR_CYC - 1);
			end
		endcase
		// settle oscillator before clocks are released.
		if (state_q == PSS_SLEEP && !osc_ok_q && cnt_done) begin
			osc_ok_d = 1'b1;
		end
		if (state_q == PSS_SLEEP && !osc_ok_q) begin
			state_d = PSS_SLEEP;
		end
		// hard reset falling edge restarts start-up.
		if (hrst_fall && state_q != PSS_SAMPLE && state_q != PSS_FLASH_EMU &&
			state_q != PSS_MIN_ENERGY) begin
			state_d = PSS_FUSE;
			cnt_d = PSS_CNT_W'(FUSE_CYC - 1);
			fuse_d = 1'b0;
			osc_ok_d = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= PSS_POR;
			cnt_q <= PSS_CNT_W'(POR_CYC - 1);
			io_dir_q <= '0;
			fuse_q <= 1'b0;
			osc_ok_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			io_dir_q <= io_dir_d;
			fuse_q <= fuse_d;
			osc_ok_q <= osc_ok_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power controls.

	pss_power_type power_d, power_q;
	logic wake_d, wake_q;

	always_comb begin
		power_d = '0;
		wake_d = (state_q == PSS_DOZE) && (demand_any || io_act);
		// low-frequency oscillator and timers run in every non-minimum state.
		power_d.lf_osc_en = (state_d != PSS_MIN_ENERGY);
		power_d.timers_en = (state_d != PSS_MIN_ENERGY);
		power_d.core_pwr_en = (state_d != PSS_MIN_ENERGY);
		case (state_d)
			PSS_POR, PSS_FUSE, PSS_SAMPLE, PSS_BOOT: begin
				power_d.relax_osc_en = 1'b1;
				power_d.cpu_clk_en = (state_d == PSS_BOOT);
			end
			PSS_FLASH_EMU: begin
				// emulate serial flash, normal operation off.
				power_d.relax_osc_en = 1'b1;
				power_d.flash_emu_en = 1'b1;
			end
			PSS_RUN, PSS_SLEEP: begin
				power_d.relax_osc_en = 1'b1;
				power_d.normal_op_en = 1'b1;
				power_d.cpu_clk_en = (state_d == PSS_RUN) && osc_ok_d;
				power_d.periph_clk_en = osc_ok_d && (demand.periph_busy || demand.dma_busy);
			end
			PSS_DOZE: begin
				power_d.retain_en = 1'b1;
				power_d.normal_op_en = 1'b1;
				power_d.io_wake_en = 1'b1;
			end
			default: begin
				power_d = '0;
			end
		endcase
		if (state_d == PSS_MIN_ENERGY) begin
			power_d.retain_en = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			power_q <= '0;
			wake_q <= 1'b0;
		end else begin
			power_q <= power_d;
			wake_q <= wake_d;
		end
	end

	assign power = power_q;
	assign state = state_q;
	assign io_dir = io_dir_q;
	assign fuse_loaded = fuse_q;
	assign wake_event = wake_q;

endmodule

/* tb/pss_seq_props.sv */
// Checker of the power state sequencer outputs.
`timescale 1ns/10ps
module pss_seq_props #(
	parameter int BOOT_CYC = 64
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic hard_rst_l,
	input wire logic prog_mode_req_l,
	input wire pss_pkg::pss_demand_type demand,
	input wire pss_pkg::pss_power_type power,
	input wire pss_pkg::pss_state_type state
);
	import pss_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic [15:0] boot_q;
	logic busy_any;
	assign busy_any = demand.cpu_busy || demand.periph_busy || demand.dma_busy ||
		demand.irq_pending;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			boot_q <= 16'h0000;
		end else begin
			boot_q <= (state == PSS_BOOT) ? boot_q + 16'h0001 : 16'h0000;
		end
	end
	sequence s_both_low;
		(!hard_rst_l && !prog_mode_req_l)[*3] ##0 state == PSS_SAMPLE;
	endsequence
	sequence s_rst_held;
		(!hard_rst_l)[*3] ##0 state == PSS_MIN_ENERGY;
	endsequence
	AST_EMU_SEL:
		assert property (s_both_low |=> state == PSS_FLASH_EMU) else $error("no emu");
	AST_MIN_HOLD:
		assert property (s_rst_held |=> state == PSS_MIN_ENERGY) else $error("min left");
	AST_BOOT_LEN:
		assert property ($fell(state == PSS_BOOT) |-> boot_q == 16'(BOOT_CYC)
			&& state == PSS_RUN) else $error("boot len");
	AST_RESTART:
		assert property ($fell(hard_rst_l) && state == PSS_RUN |-> ##[1:4]
			state == PSS_FUSE) else $error("no restart");
	AST_EMU_PWR:
		assert property (state == PSS_FLASH_EMU |-> power.flash_emu_en
			&& !power.normal_op_en) else $error("emu power");
	AST_DOZE_PWR:
		assert property (state == PSS_DOZE |-> power.lf_osc_en && power.timers_en
			&& power.retain_en && power.io_wake_en) else $error("doze power");
	AST_DOZE_IDLE:
		assert property ($rose(state == PSS_DOZE) |-> !$past(busy_any))
			else $error("doze busy");
	AST_DOZE_WAKE:
		assert property (state == PSS_DOZE && busy_any |-> ##[1:2]
			state == PSS_SLEEP) else $error("no wake");
endmodule
bind pss_sequencer pss_seq_props #(.BOOT_CYC(BOOT_CYC)) i_props (.clock(clock),
	.arst_n(arst_n), .hard_rst_l(hard_rst_l), .prog_mode_req_l(prog_mode_req_l),
	.demand(demand), .power(power), .state(state));

/* tb/pss_host_model.sv */
// Host model driving the hard reset and program request pins.
`timescale 1ns/10ps
module pss_host_model (
	input wire logic clock,
	input wire logic rst_req,
	input wire logic prog_req,
	input wire logic slow,
	output logic hard_rst_l,
	output logic prog_mode_req_l
);
	logic [1:0] rst_q = 2'h0;
	logic [1:0] prog_q = 2'h0;
	always @(posedge clock) begin
		rst_q <= {rst_q[0], rst_req};
		prog_q <= {prog_q[0], prog_req};
	end
	assign hard_rst_l = !(slow ? rst_q[1] : rst_q[0]);
	assign prog_mode_req_l = !(slow ? prog_q[1] : prog_q[0]);
endmodule

/* tb/test_power_state_sequencer.sv */
// Self-checking bench of the power state sequencer.
`timescale 1ns/10ps
module test_power_state_sequencer;
	import pss_pkg::*;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic rst_req = 1'b0;
	logic prog_req = 1'b0;
	logic slow = 1'b0;
	logic [2:0] io_l = 3'h7;
	pss_demand_type demand = 5'h00;
	logic hard_rst_l;
	logic prog_mode_req_l;
	pss_power_type power;
	pss_state_type state;
	logic [15:0] io_dir;
	logic fuse_loaded;
	logic wake_event;
	int n_fail = 0;
	int total_checks = 0;
	always #25 clock = ~clock;
	pss_host_model i_host (.clock(clock), .rst_req(rst_req), .prog_req(prog_req),
		.slow(slow), .hard_rst_l(hard_rst_l), .prog_mode_req_l(prog_mode_req_l));
	pss_sequencer #(.POR_CYC(2), .FUSE_CYC(2), .BOOT_CYC(4), .OSC_CYC(4)) i_dut (
		.clock(clock), .arst_n(arst_n), .hard_rst_l(hard_rst_l),
		.prog_mode_req_l(prog_mode_req_l), .time_capture_req_l(io_l[2]),
		.uart_rx_l(io_l[1]), .uart_rts_l(io_l[0]), .demand(demand), .fuse_data(16'hA5C3),
		.power(power), .state(state), .io_dir(io_dir), .fuse_loaded(fuse_loaded),
		.wake_event(wake_event));
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk_b(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t %s", $time, what);
		end
	endtask
	task automatic reach(input pss_state_type s, input string what);
		int i;
		@(negedge clock);
		for (i = 0; i < 200 && state !== s; i++) begin
			@(negedge clock);
		end
		chk_b(state === s, 1'b1, what);
		if (state !== s) begin
			summarize();
		end
	endtask
	task automatic t_boot();
		reach(PSS_RUN, "boot");
		chk_b(fuse_loaded, 1'b1, "fuse");
		chk_b(io_dir === 16'hA5C3, 1'b1, "io dir");
		chk_b(power.relax_osc_en, 1'b1, "osc");
		$display("boot done");
	endtask
	task automatic t_min();
		@(posedge clock) rst_req <= 1'b1;
		reach(PSS_FUSE, "restart");
		reach(PSS_MIN_ENERGY, "min");
		repeat (20) @(negedge clock);
		chk_b(state === PSS_MIN_ENERGY, 1'b1, "min hold");
		chk_b(power.core_pwr_en, 1'b0, "min power");
		@(posedge clock) rst_req <= 1'b0;
		reach(PSS_BOOT, "reboot");
		reach(PSS_RUN, "rerun");
		$display("min energy done");
	endtask
	task automatic t_emu();
		@(posedge clock) begin
			slow <= 1'b1;
			prog_req <= 1'b1;
		end
		repeat (4) @(posedge clock);
		rst_req <= 1'b1;
		reach(PSS_FLASH_EMU, "emu");
		chk_b(power.normal_op_en, 1'b0, "normal op");
		@(posedge clock) begin
			rst_req <= 1'b0;
			prog_req <= 1'b0;
		end
		reach(PSS_RUN, "emu exit");
		$display("emulation done");
	endtask
	task automatic t_doze();
		int i;
		@(posedge clock) demand <= 5'h08;
		reach(PSS_SLEEP, "wfi");
		@(posedge clock) demand <= 5'h00;
		reach(PSS_DOZE, "doze");
		chk_b(power.lf_osc_en & power.timers_en, 1'b1, "lf osc");
		for (i = 0; i < 4; i++) begin
			@(posedge clock) begin
				demand <= (i == 3) ? 5'h02 : 5'h00;
				io_l <= (i == 3) ? 3'h7 : ~(3'h1 << i);
			end
			reach(PSS_SLEEP, "wake");
			chk_b(wake_event, 1'b1, "wake pulse");
			@(posedge clock) begin
				demand <= 5'h00;
				io_l <= 3'h7;
			end
			reach(PSS_DOZE, "redoze");
		end
		@(posedge clock) demand <= 5'h10;
		reach(PSS_RUN, "resume");
		$display("doze done");
	endtask
	initial begin
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		t_boot();
		t_min();
		t_emu();
		t_doze();
		summarize();
	end
endmodule
